// [verilog/pbccd_defs.svh]
// constants of the packet buffer copy and checksum engine
// Function
// R1: copy bytes within the 8-Kbyte packet buffer
// R2: compute 16-bit internet-style checksum over range
// R3: source pointers select range, destination places copy
// R4: pointers address only the packet buffer
// R5: start loads source start into internal pointer
// R6: one byte per step, then pointer increments
// R7: pointer at ring end reloads ring start
// R8: ends at source end; unreachable means endless
// R9: clearing go/busy aborts, registers unchanged
// R10: firmware keeps pointers and mode steady while busy
// R11: firmware never starts with start equal end
// R12: firmware waits four cycles before restarting
// R13: firmware avoids data port during copy
// R14: destination linear, wraps only 8191 to 0
// R15: firmware programs pointers, clears mode, sets go
// R16: firmware enables interrupts, clears flag, then starts
// R17: pending transmit defers the copy
// R18: completion clears go/busy, sets flag, interrupts
// R19: completion of copy leaves pointers, result unchanged
// R20: copy takes one cycle per byte
// R21: receive write stalls engine that cycle
// R22: go/busy starts and shows busy; mode selects checksum
// R23: checksum is complemented ones-complement big-endian sum
`ifndef PBCCD_DEFS_SVH
`define PBCCD_DEFS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define PBCCD_AW 13
`define PBCCD_DW 16
`define PBCCD_RAW 4

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PBCCD_REG_CTRL 4'h0
`define PBCCD_REG_IRQEN 4'h1
`define PBCCD_REG_FLAG 4'h2
`define PBCCD_REG_SRC_START 4'h3
`define PBCCD_REG_SRC_END 4'h4
`define PBCCD_REG_DST_START 4'h5
`define PBCCD_REG_RX_START 4'h6
`define PBCCD_REG_RX_END 4'h7
`define PBCCD_REG_SUM 4'h8
`define PBCCD_REG_IPTR 4'h9

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define PBCCD_BIT_GO 5
`define PBCCD_BIT_SUM 4
`define PBCCD_BIT_DMA_IE 5
`define PBCCD_BIT_ETH_IE 0
`define PBCCD_BIT_FLAG 5
`define PBCCD_PTR_RST 13'h0000
`define PBCCD_PTR_ONE 13'h0001
`define PBCCD_WORD_RST 16'h0000
`define PBCCD_BYTE_RST 8'h00
`define PBCCD_CNT_ZERO 2'h0
`define PBCCD_CNT_LIMIT 3'h2

`endif

// [verilog/pbccd_pkg.sv]
// types of the packet buffer copy and checksum engine
`default_nettype none
`include "pbccd_defs.svh"

package pbccd_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT_TX = 2'b01,
    ST_RUN = 2'b10
  } pbccd_state_t;

  typedef struct packed {
    pbccd_state_t state;
    logic go;
    logic sumMode;
    logic dmaIrqEn;
    logic ethIrqEn;
    logic flag;
    logic [`PBCCD_AW-1:0] srcStart;
    logic [`PBCCD_AW-1:0] srcEnd;
    logic [`PBCCD_AW-1:0] dstStart;
    logic [`PBCCD_AW-1:0] rxStart;
    logic [`PBCCD_AW-1:0] rxEnd;
    logic [`PBCCD_DW-1:0] sumResult;
    logic [`PBCCD_AW-1:0] srcPtr;
    logic [`PBCCD_AW-1:0] dstPtr;
    logic readsDone;
    logic rdPend;
    logic oddByte;
    logic [`PBCCD_DW-1:0] acc;
    logic [7:0] h0;
    logic [7:0] h1;
    logic [1:0] cnt;
    logic [`PBCCD_DW-1:0] rdData;
    logic memRdEn;
    logic [`PBCCD_AW-1:0] memRdAddr;
    logic memWrEn;
    logic [`PBCCD_AW-1:0] memWrAddr;
    logic [7:0] memWrData;
    logic irq;
  } pbccd_regs_t;

endpackage : pbccd_pkg
`default_nettype wire

// [verilog/pbccd_ones_add.sv]
// ones-complement 16-bit adder with end-around carry
`timescale 1ns/1ps
`default_nettype none
`include "pbccd_defs.svh"

module pbccd_ones_add (
  input wire logic [`PBCCD_DW-1:0] a,
  input wire logic [`PBCCD_DW-1:0] b,
  output logic [`PBCCD_DW-1:0] sum
);

  logic [`PBCCD_DW:0] raw;

  assign raw = {1'b0, a} + {1'b0, b};
  // carry folds back in; cannot carry again since a+b <= 2*ffff
  assign sum = raw[`PBCCD_DW-1:0] + {{(`PBCCD_DW-1){1'b0}}, raw[`PBCCD_DW]};

endmodule : pbccd_ones_add
`default_nettype wire

// [verilog/pbccd_top.sv]
// packet buffer copy and checksum engine with register port
`timescale 1ns/1ps
`default_nettype none
`include "pbccd_defs.svh"

module pbccd_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [`PBCCD_RAW-1:0] regAddr,
  input wire logic [`PBCCD_DW-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`PBCCD_DW-1:0] regRdData,
  input wire logic txRequest,
  input wire logic rxWriteReq,
  output logic memRdEn,
  output logic [`PBCCD_AW-1:0] memRdAddr,
  input wire logic [7:0] memRdData,
  output logic memWrEn,
  output logic [`PBCCD_AW-1:0] memWrAddr,
  output logic [7:0] memWrData,
  output logic dmaGoBusy,
  output logic dmaIrq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pbccd_pkg::pbccd_regs_t s_r;
  pbccd_pkg::pbccd_regs_t s_nxt;

  logic running;
  logic stall;
  logic arrive;
  logic have;
  logic pop;
  logic issue;
  logic doneEv;
  logic ctrlWr;
  logic startEv;
  logic abortEv;
  logic [2:0] cntAfter;
  logic [7:0] head;
  logic [7:0] e0;
  logic [7:0] e1;
  logic [`PBCCD_DW-1:0] addend;
  logic [`PBCCD_DW-1:0] accSum;

  // ----------------------------------------------------------------
  // datapath helpers
  // ----------------------------------------------------------------
  assign running = s_r.state == pbccd_pkg::ST_RUN;
  // receive writes have priority over every engine access
  assign stall = rxWriteReq; // R21
  // read data returns the cycle after the read was presented
  assign arrive = s_r.rdPend;
  assign e0 = (s_r.cnt != `PBCCD_CNT_ZERO) ? s_r.h0 : memRdData;
  assign e1 = (s_r.cnt > 2'h1) ? s_r.h1 : memRdData;
  assign head = e0;
  assign have = running && ((s_r.cnt != `PBCCD_CNT_ZERO) || arrive);
  // summing touches no memory, so it drains even while stalled
  assign pop = have && (s_r.sumMode || !stall);
  assign cntAfter = {1'b0, s_r.cnt} + {2'h0, arrive} - {2'h0, pop};
  // outstanding bytes never exceed the two holding slots
  assign issue = running && !s_r.readsDone && !stall
    && ((cntAfter + {2'h0, s_r.memRdEn}) < `PBCCD_CNT_LIMIT);
  assign doneEv = running && s_r.readsDone && !s_r.memRdEn && (cntAfter == 3'h0);
  assign ctrlWr = regWr && (regAddr == `PBCCD_REG_CTRL);
  assign startEv = ctrlWr && regWrData[`PBCCD_BIT_GO] && (s_r.state == pbccd_pkg::ST_IDLE);
  assign abortEv = ctrlWr && !regWrData[`PBCCD_BIT_GO]
    && (s_r.state != pbccd_pkg::ST_IDLE) && !doneEv;
  // big-endian pairing: even byte is the high half
  assign addend = s_r.oddByte ? {`PBCCD_BYTE_RST, head} : {head, `PBCCD_BYTE_RST}; // R23

  pbccd_ones_add u_add (
    .a(s_r.acc),
    .b(addend),
    .sum(accSum)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.memRdEn = 1'b0;
    s_nxt.memWrEn = 1'b0;
    s_nxt.rdData = `PBCCD_WORD_RST;
    s_nxt.rdPend = s_r.memRdEn;

    if (s_r.state == pbccd_pkg::ST_WAIT_TX && !txRequest)
    begin
      s_nxt.state = pbccd_pkg::ST_RUN; // R17
    end

    if (running)
    begin
      if (issue)
      begin
        s_nxt.memRdEn = 1'b1; // R6 R20
        s_nxt.memRdAddr = s_r.srcPtr; // R3 R4
        if (s_r.srcPtr == s_r.srcEnd)
        begin
          s_nxt.readsDone = 1'b1; // R8
        end
        else if (s_r.srcPtr == s_r.rxEnd)
        begin
          s_nxt.srcPtr = s_r.rxStart; // R7
        end
        else
        begin
          s_nxt.srcPtr = s_r.srcPtr + `PBCCD_PTR_ONE; // R6
        end
      end
      s_nxt.h0 = pop ? e1 : e0;
      s_nxt.h1 = e1;
      s_nxt.cnt = cntAfter[1:0];
      if (pop)
      begin
        s_nxt.oddByte = !s_r.oddByte;
        if (s_r.sumMode)
        begin
          s_nxt.acc = accSum; // R2
        end
        else
        begin
          s_nxt.memWrEn = 1'b1; // R1
          s_nxt.memWrAddr = s_r.dstPtr;
          s_nxt.memWrData = head;
          // 13-bit counter rolls 8191 to 0, ring bounds ignored
          s_nxt.dstPtr = s_r.dstPtr + `PBCCD_PTR_ONE; // R14
        end
      end
      if (doneEv)
      begin
        s_nxt.state = pbccd_pkg::ST_IDLE;
        s_nxt.go = 1'b0; // R18
        if (s_r.sumMode)
        begin
          s_nxt.sumResult = ~(pop ? accSum : s_r.acc); // R23
        end
      end
    end

    // register writes
    if (regWr)
    begin
      case (regAddr)
        `PBCCD_REG_CTRL:
        begin
          s_nxt.sumMode = regWrData[`PBCCD_BIT_SUM]; // R22
          if (startEv)
          begin
            s_nxt.go = 1'b1; // R22
            s_nxt.srcPtr = s_r.srcStart; // R5
            s_nxt.dstPtr = s_r.dstStart; // R3
            s_nxt.readsDone = 1'b0;
            s_nxt.oddByte = 1'b0;
            s_nxt.acc = `PBCCD_WORD_RST;
            s_nxt.cnt = `PBCCD_CNT_ZERO;
            s_nxt.state = txRequest ? pbccd_pkg::ST_WAIT_TX : pbccd_pkg::ST_RUN; // R17
          end
          else if (abortEv)
          begin
            // nothing but the engine stops; copied bytes stay
            s_nxt.go = 1'b0; // R9
            s_nxt.state = pbccd_pkg::ST_IDLE;
            s_nxt.cnt = `PBCCD_CNT_ZERO;
            s_nxt.srcPtr = s_r.srcPtr;
            s_nxt.dstPtr = s_r.dstPtr;
            s_nxt.readsDone = s_r.readsDone;
            s_nxt.acc = s_r.acc;
            s_nxt.memRdEn = 1'b0;
            s_nxt.memWrEn = 1'b0;
          end
        end
        `PBCCD_REG_IRQEN:
        begin
          s_nxt.dmaIrqEn = regWrData[`PBCCD_BIT_DMA_IE];
          s_nxt.ethIrqEn = regWrData[`PBCCD_BIT_ETH_IE];
        end
        `PBCCD_REG_FLAG:
        begin
          s_nxt.flag = regWrData[`PBCCD_BIT_FLAG];
        end
        `PBCCD_REG_SRC_START:
        begin
          s_nxt.srcStart = regWrData[`PBCCD_AW-1:0];
        end
        `PBCCD_REG_SRC_END:
        begin
          s_nxt.srcEnd = regWrData[`PBCCD_AW-1:0];
        end
        `PBCCD_REG_DST_START:
        begin
          s_nxt.dstStart = regWrData[`PBCCD_AW-1:0];
        end
        `PBCCD_REG_RX_START:
        begin
          s_nxt.rxStart = regWrData[`PBCCD_AW-1:0];
        end
        `PBCCD_REG_RX_END:
        begin
          s_nxt.rxEnd = regWrData[`PBCCD_AW-1:0];
        end
        default:
        begin
          s_nxt.flag = s_nxt.flag;
        end
      endcase
    end

    // hardware set beats a same-cycle software clear
    if (doneEv)
    begin
      s_nxt.flag = 1'b1; // R18
    end
    s_nxt.irq = s_nxt.flag && s_nxt.dmaIrqEn && s_nxt.ethIrqEn; // R18

    // register reads, answered next cycle
    if (regRd)
    begin
      case (regAddr)
        `PBCCD_REG_CTRL:
        begin
          s_nxt.rdData[`PBCCD_BIT_GO] = s_r.go; // R22
          s_nxt.rdData[`PBCCD_BIT_SUM] = s_r.sumMode;
        end
        `PBCCD_REG_IRQEN:
        begin
          s_nxt.rdData[`PBCCD_BIT_DMA_IE] = s_r.dmaIrqEn;
          s_nxt.rdData[`PBCCD_BIT_ETH_IE] = s_r.ethIrqEn;
        end
        `PBCCD_REG_FLAG:
        begin
          s_nxt.rdData[`PBCCD_BIT_FLAG] = s_r.flag;
        end
        `PBCCD_REG_SRC_START:
        begin
          s_nxt.rdData = {3'h0, s_r.srcStart};
        end
        `PBCCD_REG_SRC_END:
        begin
          s_nxt.rdData = {3'h0, s_r.srcEnd};
        end
        `PBCCD_REG_DST_START:
        begin
          s_nxt.rdData = {3'h0, s_r.dstStart};
        end
        `PBCCD_REG_RX_START:
        begin
          s_nxt.rdData = {3'h0, s_r.rxStart};
        end
        `PBCCD_REG_RX_END:
        begin
          s_nxt.rdData = {3'h0, s_r.rxEnd};
        end
        `PBCCD_REG_SUM:
        begin
          s_nxt.rdData = s_r.sumResult;
        end
        `PBCCD_REG_IPTR:
        begin
          s_nxt.rdData = {3'h0, s_r.srcPtr};
        end
        default:
        begin
          s_nxt.rdData = `PBCCD_WORD_RST;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.state <= pbccd_pkg::ST_IDLE;
      s_r.srcPtr <= `PBCCD_PTR_RST;
      s_r.sumResult <= `PBCCD_WORD_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign regRdData = s_r.rdData;
  assign memRdEn = s_r.memRdEn;
  assign memRdAddr = s_r.memRdAddr;
  assign memWrEn = s_r.memWrEn;
  assign memWrAddr = s_r.memWrAddr;
  assign memWrData = s_r.memWrData;
  assign dmaGoBusy = s_r.go;
  assign dmaIrq = s_r.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_start_load;
    startEv |=> (s_r.srcPtr == $past(s_r.srcStart)) && s_r.go;
  endproperty
  a_start_load: assert property (p_start_load) else $error("start did not load source"); // R5

  property p_step;
    s_r.memRdEn && s_r.memRdAddr != s_r.rxEnd && !s_r.readsDone && running
      |-> s_r.srcPtr == s_r.memRdAddr + `PBCCD_PTR_ONE;
  endproperty
  a_step: assert property (p_step) else $error("source pointer did not advance by one"); // R6

  property p_ring_wrap;
    s_r.memRdEn && s_r.memRdAddr == s_r.rxEnd && !s_r.readsDone && running
      |-> s_r.srcPtr == s_r.rxStart;
  endproperty
  a_ring_wrap: assert property (p_ring_wrap) else $error("ring wrap not taken"); // R7

  property p_last_read;
    s_r.memRdEn && s_r.memRdAddr == s_r.srcEnd |=> !s_r.memRdEn;
  endproperty
  a_last_read: assert property (p_last_read) else $error("read after end pointer"); // R8

  property p_abort;
    abortEv |=> !s_r.go && !s_r.memRdEn && !s_r.memWrEn && $stable(s_r.flag)
      && $stable(s_r.sumResult);
  endproperty
  a_abort: assert property (p_abort) else $error("abort changed state"); // R9

  property p_dst_linear;
    s_r.memWrEn |=> !s_r.memWrEn || s_r.memWrAddr == $past(s_r.memWrAddr) + `PBCCD_PTR_ONE;
  endproperty
  a_dst_linear: assert property (p_dst_linear) else $error("destination not linear"); // R14

  property p_tx_defer;
    s_r.state == pbccd_pkg::ST_WAIT_TX ##0 txRequest |=> !s_r.memRdEn ##1 !s_r.memRdEn;
  endproperty
  a_tx_defer: assert property (p_tx_defer) else $error("access during transmit"); // R17

  property p_done;
    doneEv |=> !s_r.go && s_r.flag && (s_r.irq == (s_r.dmaIrqEn && s_r.ethIrqEn));
  endproperty
  a_done: assert property (p_done) else $error("completion not flagged"); // R18

  property p_copy_keeps;
    doneEv && !s_r.sumMode |=> $stable(s_r.sumResult) && $stable(s_r.srcStart)
      && $stable(s_r.dstStart);
  endproperty
  a_copy_keeps: assert property (p_copy_keeps) else $error("copy changed registers"); // R19

  property p_rx_yield;
    rxWriteReq |=> !s_r.memRdEn && !s_r.memWrEn;
  endproperty
  a_rx_yield: assert property (p_rx_yield) else $error("engine used buffer on receive"); // R21

  property p_sum_result;
    doneEv && s_r.sumMode |=> s_r.sumResult == ~s_r.acc;
  endproperty
  a_sum_result: assert property (p_sum_result) else $error("checksum result wrong"); // R23

  c_copy_done: cover property (doneEv && !s_r.sumMode);
  c_sum_done: cover property (doneEv && s_r.sumMode);
  c_wrap: cover property (s_r.memRdEn && s_r.memRdAddr == s_r.rxEnd && !s_r.readsDone);
  c_stall: cover property (running && rxWriteReq && !s_r.sumMode);

endmodule : pbccd_top
`default_nettype wire

// [testbench/pbccd_tb.sv]
// self-checking bench for the packet buffer copy and checksum engine
`timescale 1ns/1ps
`default_nettype none
`include "pbccd_defs.svh"

module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [3:0] A_CTRL = `PBCCD_REG_CTRL;
  localparam logic [3:0] A_EN = `PBCCD_REG_IRQEN;
  localparam logic [3:0] A_FLAG = `PBCCD_REG_FLAG;
  localparam logic [3:0] A_SS = `PBCCD_REG_SRC_START;
  localparam logic [3:0] A_SE = `PBCCD_REG_SRC_END;
  localparam logic [3:0] A_DS = `PBCCD_REG_DST_START;
  localparam logic [3:0] A_SUM = `PBCCD_REG_SUM;
  localparam int RXS = 20;
  localparam int RXE = 29;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdData;
  logic txRequest = 1'b0;
  logic rxWriteReq = 1'b0;
  logic memRdEn;
  logic [12:0] memRdAddr;
  logic [7:0] memRdData = 8'h00;
  logic memWrEn;
  logic [12:0] memWrAddr;
  logic [7:0] memWrData;
  logic dmaGoBusy;
  logic dmaIrq;
  logic [7:0] mem [0:8191];
  logic [7:0] expMem [0:8191];
  logic [7:0] lfsr = 8'h0e;
  logic stallOn = 1'b0;
  logic prevRx = 1'b0;
  logic [15:0] sumKeep = 16'h0000;
  int bad_count = 0;
  int total_checks = 0;
  int rdCount = 0;
  int wrCount = 0;

  always #2 ref_clk = ~ref_clk;

  pbccd_top DUT (
    .ref_clk(ref_clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData(regRdData),
    .txRequest(txRequest),
    .rxWriteReq(rxWriteReq),
    .memRdEn(memRdEn),
    .memRdAddr(memRdAddr),
    .memRdData(memRdData),
    .memWrEn(memWrEn),
    .memWrAddr(memWrAddr),
    .memWrData(memWrData),
    .dmaGoBusy(dmaGoBusy),
    .dmaIrq(dmaIrq)
  );

  // ----------------------------------------------------------------
  // buffer memory and receive traffic
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr_next

  // idle read data toggles so a stale byte is never taken for fresh
  always @(posedge ref_clk)
  begin
    prevRx <= rxWriteReq;
    if (memRdEn === 1'b1)
    begin
      memRdData <= mem[memRdAddr];
      rdCount <= rdCount + 1;
    end
    else
      memRdData <= ~memRdData;
    if (memWrEn === 1'b1)
    begin
      mem[memWrAddr] <= memWrData;
      wrCount <= wrCount + 1;
    end
    if (stallOn)
    begin
      lfsr <= lfsr_next(lfsr);
      rxWriteReq <= lfsr[0] & lfsr[1];
    end
    else
      rxWriteReq <= 1'b0;
  end

  always @(negedge ref_clk)
    if (prevRx === 1'b1)
      check({14'h0000, memRdEn, memWrEn}, 16'h0000);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    check(regRdData, e);
  endtask : rd_chk

  task automatic wait_done(output int n);
    n = 0;
    #1;
    while (dmaGoBusy !== 1'b0)
    begin
      n++;
      if (n > 5000)
      begin
        bad_count++;
        $display("[ERR] %0t engine never finished", $time);
        stop_test();
      end
      @(posedge ref_clk);
      #1;
    end
  endtask : wait_done

  task automatic run_op(input int s, input int e, input int d, input logic sm,
    input logic tx, input logic st, input logic [15:0] irqEn);
    int q[$];
    int p;
    int n;
    int acc;
    logic [15:0] w;
    p = s;
    q.push_back(p);
    while (p != e && q.size() < 9000)
    begin
      p = (p == RXE) ? RXS : (p + 1) % 8192;
      q.push_back(p);
    end
    for (int k = 0; k < 8192; k++)
      expMem[k] = mem[k];
    acc = 0;
    for (int i = 0; i < q.size(); i++)
      if (!sm)
        expMem[(d + i) % 8192] = mem[q[i]];
    for (int i = 0; i < q.size(); i += 2)
    begin
      w = {mem[q[i]], (i + 1 < q.size()) ? mem[q[i + 1]] : 8'h00};
      acc = acc + w;
      acc = (acc & 32'h0000_ffff) + (acc >> 16);
    end
    stallOn <= st;
    reg_wr(A_SS, s[15:0]);
    reg_wr(A_SE, e[15:0]);
    reg_wr(A_DS, d[15:0]);
    reg_wr(A_EN, irqEn);
    reg_wr(A_FLAG, 16'h0000);
    // restart spacing kept well above the minimum
    repeat (6) @(posedge ref_clk);
    txRequest <= tx;
    reg_wr(A_CTRL, {10'h000, 1'b1, sm, 4'h0});
    if (tx)
    begin
      p = rdCount;
      repeat (8) @(posedge ref_clk);
      #1;
      check(16'(rdCount - p), 16'h0000);
      check({15'h0000, dmaGoBusy}, 16'h0001);
      rd_chk(A_CTRL, {10'h000, 1'b1, sm, 4'h0});
      @(posedge ref_clk);
      txRequest <= 1'b0;
    end
    wait_done(n);
    stallOn <= 1'b0;
    // start edge to first read is one cycle, last read to last write two
    if (!tx && !st && !sm)
      check(16'(n), 16'(q.size() + 2));
    rd_chk(A_FLAG, 16'h0020);
    check({15'h0000, dmaIrq}, {15'h0000, irqEn == 16'h0021});
    n = 0;
    for (int k = 0; k < 8192; k++)
      if (mem[k] !== expMem[k])
        n++;
    check(16'(n), 16'h0000);
    if (sm)
      sumKeep = ~acc[15:0];
    rd_chk(A_SUM, sumKeep);
    rd_chk(A_SS, s[15:0]);
    rd_chk(A_SE, e[15:0]);
  endtask : run_op

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int w0;
    for (int k = 0; k < 8192; k++)
    begin
      lfsr = lfsr_next(lfsr);
      mem[k] = lfsr;
    end
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 0; a < 11; a++)
      rd_chk(4'(a), 16'h0000);
    check({14'h0000, dmaGoBusy, dmaIrq}, 16'h0000);
    reg_wr(A_DS, 16'hffff);
    rd_chk(A_DS, 16'h1fff);
    reg_wr(4'hf, 16'hffff);
    rd_chk(4'hf, 16'h0000);
    reg_wr(`PBCCD_REG_RX_START, 16'(RXS));
    reg_wr(`PBCCD_REG_RX_END, 16'(RXE));
    run_op(300, 309, 0, 1'b1, 1'b0, 1'b1, 16'h0021);
    run_op(27, 21, 0, 1'b1, 1'b0, 1'b0, 16'h0021);
    run_op(25, 22, 8190, 1'b0, 1'b0, 1'b0, 16'h0021);
    reg_wr(A_FLAG, 16'h0000);
    @(posedge ref_clk);
    #1;
    check({15'h0000, dmaIrq}, 16'h0000);
    // interrupt masked by clearing the eth enable only
    run_op(1000, 1011, 25, 1'b0, 1'b1, 1'b1, 16'h0020);
    reg_wr(A_SS, 16'h07d0);
    reg_wr(A_SE, 16'h0bb7);
    reg_wr(A_DS, 16'h1000);
    reg_wr(A_FLAG, 16'h0000);
    repeat (6) @(posedge ref_clk);
    reg_wr(A_CTRL, 16'h0020);
    repeat (5) @(posedge ref_clk);
    reg_wr(A_CTRL, 16'h0000);
    repeat (3) @(posedge ref_clk);
    #1;
    check({15'h0000, dmaGoBusy}, 16'h0000);
    w0 = wrCount;
    repeat (6) @(posedge ref_clk);
    #1;
    check(16'(wrCount - w0), 16'h0000);
    rd_chk(A_FLAG, 16'h0000);
    rd_chk(A_SS, 16'h07d0);
    rd_chk(A_SUM, sumKeep);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
